// ### rtl/fcbu_branch.sv
// Flag conditional branch unit: four-phase execute of five relative branches
// Assumes instr and flags stable from Q1 to Q4 and issued only when instr_ready is high
// Overview of operation
// - Opcode e6 branches when the negative flag is one.
// - Opcode e3 branches when the carry flag is zero.
// - Opcode e7 branches when the negative flag is zero.
// - Opcode e5 branches when the overflow flag is zero.
// - Opcode e1 branches when the zero flag is zero.
// - Low byte is a signed offset, -128 to 127, doubled before use.
// - Taken target is own address plus two plus twice the offset.
// - Taken costs two cycles, second all idle; not taken costs one.
// - Each branch is exactly one program word.
// - Q1 decode, Q2 read offset, Q3 process, Q4 write PC: target if taken, next word if not.
`timescale 1ns/1ps
`default_nettype none
`include "fcbu_consts.svh"
module fcbu_branch (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [`FCBU_PC_W-1:0] instr_addr,
  input wire logic neg_flag,
  input wire logic carry_flag,
  input wire logic overflow_flag,
  input wire logic zero_flag,
  output logic [`FCBU_PC_W-1:0] pc_out,
  output logic pc_load,
  output logic instr_done,
  output logic instr_ready,
  output var fcbu_pkg::fcbu_phase_t phase,
  output logic flags_write
);
  import fcbu_pkg::*;

  typedef struct packed {
    fcbu_phase_t phase;
    logic busy;
    logic nop_cyc;
    logic taken;
    logic [7:0] lit;
    logic [`FCBU_PC_W-1:0] target;
    logic [`FCBU_PC_W-1:0] pc;
    logic pc_load;
    logic done;
    logic ready;
    logic flags_wr;
  } fcbu_state_t;

  fcbu_state_t st_ff;
  fcbu_state_t nxt_st;
  fcbu_op_t dec_op;
  logic dec_cond;

  function automatic logic [`FCBU_PC_W-1:0] fcbu_target(
    input logic [`FCBU_PC_W-1:0] base, input logic [7:0] n);
    logic [`FCBU_PC_W-1:0] off2;
    off2 = {{(`FCBU_PC_W-9){n[7]}}, n, 1'b0};
    return base + `FCBU_WORD_BYTES + off2;
  endfunction : fcbu_target

  fcbu_decode u_dec (
    .opcode_hi(instr[15:8]),
    .neg_flag(neg_flag),
    .carry_flag(carry_flag),
    .overflow_flag(overflow_flag),
    .zero_flag(zero_flag),
    .op(dec_op),
    .cond_true(dec_cond)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pc_load = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.flags_wr = 1'b0;
    unique case (st_ff.phase)
      FCBU_Q1: begin
        nxt_st.phase = FCBU_Q2;
        if (!st_ff.nop_cyc) begin
          // Decode phase
          nxt_st.busy = instr_valid && (dec_op != FCBU_NONE);
          nxt_st.taken = instr_valid && dec_cond;
          nxt_st.ready = 1'b0;
        end
      end
      FCBU_Q2: begin
        nxt_st.phase = FCBU_Q3;
        if (st_ff.busy) begin
          nxt_st.lit = instr[7:0];
        end
      end
      FCBU_Q3: begin
        nxt_st.phase = FCBU_Q4;
        if (st_ff.busy) begin
          nxt_st.target = fcbu_target(instr_addr, st_ff.lit);
        end
      end
      FCBU_Q4: begin
        nxt_st.phase = FCBU_Q1;
        if (st_ff.nop_cyc) begin
          // Idle second cycle of a taken branch
          nxt_st.nop_cyc = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.ready = 1'b1;
        end else if (st_ff.busy && st_ff.taken) begin
          nxt_st.pc = st_ff.target;
          nxt_st.pc_load = 1'b1;
          nxt_st.nop_cyc = 1'b1;
        end else begin
          // Not taken: next word, one cycle
          if (st_ff.busy) begin
            nxt_st.pc = instr_addr + `FCBU_WORD_BYTES;
            nxt_st.pc_load = 1'b1;
          end
          nxt_st.done = st_ff.busy;
          nxt_st.ready = 1'b1;
        end
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff <= '{phase: FCBU_Q1, busy: 1'b0, nop_cyc: 1'b0, taken: 1'b0,
        lit: 8'h00, target: `FCBU_PC_RST, pc: `FCBU_PC_RST, pc_load: 1'b0,
        done: 1'b0, ready: 1'b1, flags_wr: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pc_out = st_ff.pc;
  assign pc_load = st_ff.pc_load;
  assign instr_done = st_ff.done;
  assign instr_ready = st_ff.ready;
  assign phase = st_ff.phase;
  assign flags_write = st_ff.flags_wr;

  sequence s_taken_q4;
    st_ff.phase == FCBU_Q4 && st_ff.busy && st_ff.taken && !st_ff.nop_cyc;
  endsequence

  sequence s_branch_q1;
    phase == FCBU_Q1 && !st_ff.nop_cyc && instr_valid
      && instr[15:8] inside {`FCBU_OP_NEG, `FCBU_OP_NC, `FCBU_OP_NNEG,
      `FCBU_OP_NOV, `FCBU_OP_NZ};
  endsequence

  sequence s_cond_met;
    (instr[15:8] == `FCBU_OP_NEG && neg_flag)
      || (instr[15:8] == `FCBU_OP_NC && !carry_flag)
      || (instr[15:8] == `FCBU_OP_NNEG && !neg_flag)
      || (instr[15:8] == `FCBU_OP_NOV && !overflow_flag)
      || (instr[15:8] == `FCBU_OP_NZ && !zero_flag);
  endsequence

  chk_taken_two_cyc: assert property (@(posedge clk) disable iff (!rst_b)
    s_taken_q4 |=> pc_load ##4 instr_done)
    else $error("Taken branch did not finish in two cycles");

  chk_nop_no_load: assert property (@(posedge clk) disable iff (!rst_b)
    s_taken_q4 |=> ##1 !pc_load [*4])
    else $error("PC written during idle cycle");

  chk_target_val: assert property (@(posedge clk) disable iff (!rst_b)
    s_taken_q4 |=> pc_out == $past(instr_addr) + `FCBU_WORD_BYTES
      + {{(`FCBU_PC_W-9){$past(instr[7])}}, $past(instr[7:0]), 1'b0})
    else $error("Wrong branch target");

  chk_load_in_q4: assert property (@(posedge clk) disable iff (!rst_b)
    pc_load |-> phase == FCBU_Q1 && $past(instr_valid, 4))
    else $error("PC written outside Q4");

  chk_neg_cond: assert property (@(posedge clk) disable iff (!rst_b)
    instr[15:8] == `FCBU_OP_NEG |-> dec_cond == neg_flag)
    else $error("Negative branch condition wrong");

  chk_nc_cond: assert property (@(posedge clk) disable iff (!rst_b)
    instr[15:8] == `FCBU_OP_NC |-> dec_cond == !carry_flag)
    else $error("Carry clear condition wrong");

  chk_nneg_cond: assert property (@(posedge clk) disable iff (!rst_b)
    instr[15:8] == `FCBU_OP_NNEG |-> dec_cond == !neg_flag)
    else $error("Not negative condition wrong");

  chk_nov_cond: assert property (@(posedge clk) disable iff (!rst_b)
    instr[15:8] == `FCBU_OP_NOV |-> dec_cond == !overflow_flag)
    else $error("No overflow condition wrong");

  chk_nz_cond: assert property (@(posedge clk) disable iff (!rst_b)
    instr[15:8] == `FCBU_OP_NZ |-> dec_cond == !zero_flag)
    else $error("Nonzero condition wrong");

  chk_not_taken_one: assert property (@(posedge clk) disable iff (!rst_b)
    st_ff.phase == FCBU_Q4 && st_ff.busy && !st_ff.taken && !st_ff.nop_cyc
    |=> pc_load && instr_done && pc_out == $past(instr_addr) + `FCBU_WORD_BYTES)
    else $error("Not taken branch wrong");

  chk_flags_kept: assert property (@(posedge clk) disable iff (!rst_b)
    !flags_write)
    else $error("Flags written");

  chk_lit_in_q2: assert property (@(posedge clk) disable iff (!rst_b)
    s_branch_q1 |=> ##1 st_ff.lit == $past(instr[7:0]))
    else $error("Offset not read in Q2");

  chk_taken_decision: assert property (@(posedge clk) disable iff (!rst_b)
    s_branch_q1 ##0 s_cond_met |=> ##3 (pc_load && !instr_done))
    else $error("Met condition did not branch");

  chk_ready_cycles: assert property (@(posedge clk) disable iff (!rst_b)
    s_branch_q1 |=> !instr_ready [*3])
    else $error("Ready high during a branch");

  chk_ready_low_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (st_ff.busy || st_ff.nop_cyc) |-> !instr_ready)
    else $error("Ready high while busy");

  chk_ready_at_done: assert property (@(posedge clk) disable iff (!rst_b)
    instr_done |-> instr_ready && phase == FCBU_Q1)
    else $error("Done without ready at Q1");

  chk_refused_quiet: assert property (@(posedge clk) disable iff (!rst_b)
    phase == FCBU_Q1 && !st_ff.nop_cyc && (!instr_valid || !(instr[15:8] inside
    {`FCBU_OP_NEG, `FCBU_OP_NC, `FCBU_OP_NNEG, `FCBU_OP_NOV, `FCBU_OP_NZ}))
    |=> ##3 (!pc_load && !instr_done))
    else $error("Refused word acted");
endmodule : fcbu_branch
`default_nettype wire

// ### inc/fcbu_consts.svh
// Constants for the flag conditional branch unit
// Assumes a 21-bit byte program counter and 16-bit instruction words
`ifndef FCBU_CONSTS_SVH
`define FCBU_CONSTS_SVH
`define FCBU_PC_W 21
`define FCBU_OP_NEG 8'he6
`define FCBU_OP_NC 8'he3
`define FCBU_OP_NNEG 8'he7
`define FCBU_OP_NOV 8'he5
`define FCBU_OP_NZ 8'he1
`define FCBU_WORD_BYTES 21'h000002
`define FCBU_PC_RST 21'h000000
`endif

// ### inc/fcbu_pkg.sv
// Types for the flag conditional branch unit
// Assumes fcbu_consts.svh on the include path
package fcbu_pkg;
  typedef enum logic [1:0] {FCBU_Q1, FCBU_Q2, FCBU_Q3, FCBU_Q4} fcbu_phase_t;
  typedef enum logic [2:0] {FCBU_NONE, FCBU_NEG, FCBU_NC, FCBU_NNEG, FCBU_NOV,
    FCBU_NZ} fcbu_op_t;
endpackage : fcbu_pkg

// ### rtl/fcbu_decode.sv
// Opcode decode and condition test for the conditional branches
// Assumes a combinational use inside the core clock domain
`timescale 1ns/1ps
`default_nettype none
`include "fcbu_consts.svh"
module fcbu_decode (
  input wire logic [7:0] opcode_hi,
  input wire logic neg_flag,
  input wire logic carry_flag,
  input wire logic overflow_flag,
  input wire logic zero_flag,
  output var fcbu_pkg::fcbu_op_t op,
  output logic cond_true
);
  import fcbu_pkg::*;
  always_comb begin
    op = FCBU_NONE;
    cond_true = 1'b0;
    unique case (opcode_hi)
      `FCBU_OP_NEG: begin
        op = FCBU_NEG;
        cond_true = neg_flag;
      end
      `FCBU_OP_NC: begin
        op = FCBU_NC;
        cond_true = ~carry_flag;
      end
      `FCBU_OP_NNEG: begin
        op = FCBU_NNEG;
        cond_true = ~neg_flag;
      end
      `FCBU_OP_NOV: begin
        op = FCBU_NOV;
        cond_true = ~overflow_flag;
      end
      `FCBU_OP_NZ: begin
        op = FCBU_NZ;
        cond_true = ~zero_flag;
      end
      default: begin
        op = FCBU_NONE;
        cond_true = 1'b0;
      end
    endcase
  end
endmodule : fcbu_decode
`default_nettype wire

// ### verification/fcbu_core_model.sv
// Core model: program counter fed back from the branch unit
// Assumes one clock and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
`include "fcbu_consts.svh"
module fcbu_core_model #(
  parameter logic [`FCBU_PC_W-1:0] START_PC = 21'h000100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pc_load,
  input wire logic [`FCBU_PC_W-1:0] pc_out,
  output logic [`FCBU_PC_W-1:0] instr_addr
);
  logic [`FCBU_PC_W-1:0] pc_ff;
  // New address visible in the load cycle
  assign instr_addr = pc_load ? pc_out : pc_ff;
  always_ff @(posedge clk) begin
    pc_ff <= !rst_b ? START_PC : instr_addr;
  end
endmodule : fcbu_core_model
`default_nettype wire

// ### verification/tb.sv
// Testbench: all opcodes, offset limits, refusals
// Assumes the core model closes the program counter loop
`timescale 1ns/1ps
`default_nettype none
`include "fcbu_consts.svh"
module tb;
  import fcbu_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0] fl = 4'h0;
  logic [`FCBU_PC_W-1:0] pc_out, instr_addr;
  logic [`FCBU_PC_W-1:0] exp_pc = 21'h000100;
  logic pc_load, instr_done, instr_ready, flags_write;
  fcbu_phase_t phase;
  int n_mismatch = 0;
  int compares = 0;
  always #25 clk = ~clk;
  fcbu_branch dut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
    .instr_addr(instr_addr), .neg_flag(fl[3]), .carry_flag(fl[2]), .overflow_flag(fl[1]),
    .zero_flag(fl[0]), .pc_out(pc_out), .pc_load(pc_load), .instr_done(instr_done),
    .instr_ready(instr_ready), .phase(phase), .flags_write(flags_write));
  fcbu_core_model core (.clk(clk), .rst_b(rst_b), .pc_load(pc_load), .pc_out(pc_out),
    .instr_addr(instr_addr));
  task automatic report_and_stop();
    $display("Compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, m);
    end
  endtask : chk
  // One branch: wait for a free Q1, present, check each cycle
  task automatic issue(input logic [7:0] op, input logic [7:0] n, input logic [3:0] f,
    input logic tk);
    logic [`FCBU_PC_W-1:0] exp;
    int last;
    int i;
    last = tk ? 8 : 4;
    exp = exp_pc + `FCBU_WORD_BYTES + (tk ? {{12{n[7]}}, n, 1'b0} : 21'h000000);
    i = 0;
    while ((phase !== FCBU_Q1 || instr_ready !== 1'b1) && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (i == 20) begin
      chk(1'b0, "no ready slot");
      report_and_stop();
    end
    instr = {op, n};
    fl = f;
    instr_valid = 1'b1;
    for (int k = 1; k <= last; k++) begin
      @(negedge clk);
      chk(pc_load === (k == 4), "load timing");
      chk(instr_done === (k == last), "done timing");
      chk(instr_ready === (k == last), "ready level");
      chk(flags_write === 1'b0, "flag write");
      chk(k != 4 || pc_out === exp, "target");
    end
    exp_pc = exp;
  endtask : issue
  task automatic sc_reset();
    repeat (2) @(negedge clk);
    chk(pc_out === `FCBU_PC_RST && pc_load === 1'b0 && instr_done === 1'b0, "reset out");
    chk(instr_ready === 1'b1 && phase === FCBU_Q1 && flags_write === 1'b0, "reset state");
    repeat (2) @(negedge clk);
  endtask : sc_reset
  task automatic sc_all_ops();
    logic [7:0] ops [5] = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
    logic [3:0] tf [5] = '{4'b1000, 4'b1011, 4'b0111, 4'b1101, 4'b1110};
    for (int j = 0; j < 5; j++) begin
      issue(ops[j], 8'h05, tf[j], 1'b1);
      issue(ops[j], 8'hfd, ~tf[j], 1'b0);
    end
  endtask : sc_all_ops
  task automatic sc_offsets();
    issue(8'he1, 8'h80, 4'h0, 1'b1);
    issue(8'he1, 8'h7f, 4'h0, 1'b1);
    issue(8'he7, 8'h80, 4'hf, 1'b0);
  endtask : sc_offsets
  // Foreign opcode, then a valid one without the valid strobe
  task automatic sc_refused();
    for (int j = 0; j < 2; j++) begin
      instr = j ? 16'he605 : 16'he205;
      instr_valid = (j == 0);
      fl = 4'h8;
      repeat (8) begin
        @(negedge clk);
        chk(pc_load === 1'b0 && instr_done === 1'b0, "refused acted");
      end
    end
  endtask : sc_refused
  initial begin
    sc_reset();
    rst_b = 1'b1;
    sc_all_ops();
    sc_offsets();
    sc_refused();
    issue(8'he6, 8'h01, 4'h8, 1'b1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
